//--- logic/dsp_pkg.sv
// Purpose: Shared constants and types for the dual serial port pair.
// Assumes: 8-bit register port, one 100 MHz system clock.
// Notes:   Channel 0 is the first port, channel 1 the second port.
`default_nettype none

package dsp_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] DSP_ADDR_PWR_BAUD = 8'h87;
   localparam logic [7:0] DSP_ADDR_T1_RELOAD = 8'h8D;
   localparam logic [7:0] DSP_ADDR_P2_CTRL = 8'h8E;
   localparam logic [7:0] DSP_ADDR_P2_DATA = 8'h8F;
   localparam logic [7:0] DSP_ADDR_OPTIONS = 8'h94;
   localparam logic [7:0] DSP_ADDR_P1_CTRL = 8'h98;
   localparam logic [7:0] DSP_ADDR_P1_DATA = 8'h99;
   localparam logic [7:0] DSP_ADDR_RATE_SEL = 8'hC8;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int DSP_BIT_DOUBLER = 7;
   localparam int DSP_BIT_ONE_WIRE = 7;
   localparam int DSP_BIT_RX_SRC = 5;
   localparam int DSP_BIT_TX_SRC = 4;
   localparam int DSP_BIT_P2_SEL = 7;
   localparam int DSP_BIT_MP_FILTER = 5;
   localparam int DSP_BIT_RX_ALLOW = 4;
   localparam int DSP_BIT_TX_NINTH = 3;
   localparam int DSP_BIT_RX_NINTH = 2;
   localparam int DSP_BIT_TX_DONE = 1;
   localparam int DSP_BIT_RX_DONE = 0;
   localparam logic [7:0] DSP_RST_BYTE = 8'h00;

   // ------------------------------------------------------------
   // Modes and timing counts
   // ------------------------------------------------------------
   localparam logic [1:0] DSP_MODE_SHIFT = 2'h0;
   localparam logic [1:0] DSP_MODE_FIX9 = 2'h2;
   localparam logic [3:0] DSP_TICK_LAST = 4'hF;
   localparam logic [3:0] DSP_TICK_SMP_A = 4'h7;
   localparam logic [3:0] DSP_TICK_SMP_B = 4'h8;
   localparam logic [3:0] DSP_TICK_SMP_C = 4'h9;
   localparam logic [3:0] DSP_STOP_8BIT = 4'h9;
   localparam logic [3:0] DSP_STOP_9BIT = 4'hA;
   localparam logic [3:0] DSP_SHIFT_LAST = 4'h7;
   localparam logic [7:0] DSP_T1_TOP = 8'hFF;

   typedef enum logic {DSP_IDLE = 1'b0, DSP_RUN = 1'b1} dsp_run_t;

   typedef struct packed {
      logic [1:0] mode;
      logic sm2;
      logic ren;
      logic tb8;
      logic rb8;
      logic ti;
      logic ri;
      logic [7:0] rbuf;
      dsp_run_t tx_st;
      logic m0_rx;
      logic [3:0] tx_tick;
      logic [3:0] tx_bit;
      logic [8:0] tx_sh;
      dsp_run_t rx_st;
      logic [3:0] rx_tick;
      logic [3:0] rx_bit;
      logic [8:0] rx_sh;
      logic [1:0] rx_smp;
      logic rx_prev;
   } dsp_chan_t;

   typedef struct packed {
      dsp_chan_t [1:0] ch;
      logic baud_doubler;
      logic one_wire;
      logic rclk_t2;
      logic port1_tx_rate_source_t2;
      logic [7:0] th1;
      logic [7:0] t1_cnt;
      logic t1_pre;
      logic t1_half;
      logic [1:0] m2_pre;
      logic rxd_s1;
      logic rxd_s2;
      logic txp_s1;
      logic txp_s2;
      logic p2_s1;
      logic p2_s2;
      logic p1_txd;
      logic p1_txd_oe;
      logic p1_rxd;
      logic p1_rxd_oe;
      logic p2_txd;
      logic [7:0] rdata;
   } dsp_state_t;

endpackage

`default_nettype wire

//--- logic/dsp_serial_pair.sv
// Purpose: Two asynchronous serial ports with a byte-wide register port.
// Assumes: Timer2 overflow pulse arrives from same-clock logic; pins are async.
// Notes:   Timer1 runs here in auto-reload form only, as the shared rate source.
//
// Notes on behaviour
// - One-wire mode shares the transmit pin both ways
// - Data address splits write-holding and read-receive
// - Data write loads and starts a frame
// - Port one mode field picks four modes
// - Nine-bit filter drops frames with ninth zero
// - Eight-bit filter needs valid stop bit
// - Reception only while receive-enable set
// - Nine-bit frames send the transmit ninth bit
// - Receive ninth bit captures ninth or stop
// - Port one transmit flag timing, software clears
// - Port one receive flag timing, software clears
// - Port two bit picks eight or nine bits
// - Port two transmit flag at stop start
// - Port two receive flag at stop sample
// - Doubler speeds port one; port two always doubled
// - Port two has no Timer2 nor one-wire
// - Timer1 rate formula for variable modes
// - Timer2 rate is overflow over sixteen
// - Fixed nine-bit rate is clock over 64, or clock over 32 when doubled
// - Separate receive and transmit rate sources
// - Timer1 reloads low byte at overflow
//
// The plain strobed port was decided locally.
`default_nettype none

module dsp_serial_pair
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic timer2_ovf_i,
   input wire logic p1_txd_i,
   output logic p1_txd_o,
   output logic p1_txd_oe_o,
   input wire logic p1_rxd_i,
   output logic p1_rxd_o,
   output logic p1_rxd_oe_o,
   input wire logic p2_rxd_i,
   output logic p2_txd_o
);
   import dsp_pkg::*;

   dsp_state_t st_ff;
   dsp_state_t nxt_st;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic maj3(input logic a, input logic b, input logic c);
      maj3 = (a & b) | (a & c) | (b & c);
   endfunction

   function automatic logic [3:0] stop_idx(input logic nine);
      stop_idx = nine ? DSP_STOP_9BIT : DSP_STOP_8BIT;
   endfunction

   // Line level for the bit that the transmitter currently holds
   function automatic logic tx_level(input dsp_chan_t ch);
      if (ch.tx_st == DSP_IDLE)
      begin
         tx_level = 1'b1;
      end
      else if (ch.tx_bit == 4'h0)
      begin
         tx_level = 1'b0;
      end
      else if (ch.tx_bit >= stop_idx(ch.mode[1]))
      begin
         tx_level = 1'b1;
      end
      else
      begin
         tx_level = ch.tx_sh[ch.tx_bit - 4'h1];
      end
   endfunction

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      logic ovf;
      logic m2_tick;
      logic p1_t1_tick;
      logic [1:0] tk_t;
      logic [1:0] tk_r;
      logic [1:0] ln;
      logic m;
      logic nine;
      logic [7:0] ctrl_a;
      logic [7:0] data_a;
      ovf = 1'b0;
      m = 1'b0;
      nine = 1'b0;
      m2_tick = 1'b0;
      p1_t1_tick = 1'b0;
      tk_t = 2'h0;
      tk_r = 2'h0;
      ln = 2'h0;
      ctrl_a = DSP_ADDR_P1_CTRL;
      data_a = DSP_ADDR_P1_DATA;
      nxt_st = st_ff;

      // Control writes first, so hardware flag sets below win over a clear
      if (wr_i)
      begin
         case (addr_i)
            DSP_ADDR_PWR_BAUD: nxt_st.baud_doubler = wdata_i[DSP_BIT_DOUBLER];
            DSP_ADDR_OPTIONS: nxt_st.one_wire = wdata_i[DSP_BIT_ONE_WIRE];
            DSP_ADDR_T1_RELOAD: nxt_st.th1 = wdata_i;
            DSP_ADDR_RATE_SEL:
            begin
               nxt_st.rclk_t2 = wdata_i[DSP_BIT_RX_SRC];
               nxt_st.port1_tx_rate_source_t2 = wdata_i[DSP_BIT_TX_SRC];
            end
            DSP_ADDR_P1_CTRL:
            begin
               nxt_st.ch[0].mode = wdata_i[7:6];
               nxt_st.ch[0].sm2 = wdata_i[DSP_BIT_MP_FILTER];
            end
            DSP_ADDR_P2_CTRL:
            begin
               // The second port only has the two variable-rate modes
               nxt_st.ch[1].mode = {wdata_i[DSP_BIT_P2_SEL], 1'b1};
            end
            default:
            begin
            end
         endcase
      end
      for (int c = 0; c < 2; c++)
      begin
         ctrl_a = (c == 0) ? DSP_ADDR_P1_CTRL : DSP_ADDR_P2_CTRL;
         if (wr_i && addr_i == ctrl_a)
         begin
            nxt_st.ch[c].ren = wdata_i[DSP_BIT_RX_ALLOW];
            nxt_st.ch[c].tb8 = wdata_i[DSP_BIT_TX_NINTH];
            nxt_st.ch[c].rb8 = wdata_i[DSP_BIT_RX_NINTH];
            nxt_st.ch[c].ti = wdata_i[DSP_BIT_TX_DONE];
            nxt_st.ch[c].ri = wdata_i[DSP_BIT_RX_DONE];
         end
      end

      // Timer1 in auto-reload: counts every second clock
      nxt_st.t1_pre = ~st_ff.t1_pre;
      if (st_ff.t1_pre)
      begin
         if (st_ff.t1_cnt == DSP_T1_TOP)
         begin
            nxt_st.t1_cnt = st_ff.th1;
            ovf = 1'b1;
            nxt_st.t1_half = ~st_ff.t1_half;
         end
         else
         begin
            nxt_st.t1_cnt = st_ff.t1_cnt + 8'h01;
         end
      end

      // Fixed rate: 16 ticks per bit at clock/4 or clock/2
      nxt_st.m2_pre = st_ff.m2_pre + 2'h1;
      m2_tick = st_ff.baud_doubler ? st_ff.m2_pre[0] : (&st_ff.m2_pre);
      // Overflow halved unless doubled gives the 2x(256-reload)x32 divide
      p1_t1_tick = ovf & (st_ff.baud_doubler | st_ff.t1_half);
      if (st_ff.ch[0].mode == DSP_MODE_FIX9)
      begin
         tk_t[0] = m2_tick;
         tk_r[0] = m2_tick;
      end
      else
      begin
         // Each Timer2 overflow is one sixteenth of a bit
         tk_t[0] = st_ff.port1_tx_rate_source_t2 ? timer2_ovf_i : p1_t1_tick;
         tk_r[0] = st_ff.rclk_t2 ? timer2_ovf_i : p1_t1_tick;
      end
      // Second port: Timer1 only, always at the doubled rate
      tk_t[1] = ovf;
      tk_r[1] = ovf;

      // Pin synchronisers
      nxt_st.rxd_s1 = p1_rxd_i;
      nxt_st.rxd_s2 = st_ff.rxd_s1;
      nxt_st.txp_s1 = p1_txd_i;
      nxt_st.txp_s2 = st_ff.txp_s1;
      nxt_st.p2_s1 = p2_rxd_i;
      nxt_st.p2_s2 = st_ff.p2_s1;
      ln[0] = st_ff.one_wire ? st_ff.txp_s2 : st_ff.rxd_s2;
      ln[1] = st_ff.p2_s2;

      for (int c = 0; c < 2; c++)
      begin
         data_a = (c == 0) ? DSP_ADDR_P1_DATA : DSP_ADDR_P2_DATA;
         nine = st_ff.ch[c].mode[1];
         nxt_st.ch[c].rx_prev = ln[c];
         if (c == 0 && st_ff.ch[0].mode == DSP_MODE_SHIFT)
         begin
            // Shift mode: one bit per two clocks, clock low then high
            if (st_ff.ch[0].tx_st == DSP_RUN)
            begin
               nxt_st.ch[0].tx_tick = {3'h0, ~st_ff.ch[0].tx_tick[0]};
               if (st_ff.ch[0].tx_tick[0])
               begin
                  nxt_st.ch[0].tx_sh = {1'b0, st_ff.rxd_s2, st_ff.ch[0].tx_sh[7:1]};
                  nxt_st.ch[0].tx_bit = st_ff.ch[0].tx_bit + 4'h1;
                  if (st_ff.ch[0].tx_bit == DSP_SHIFT_LAST)
                  begin
                     nxt_st.ch[0].tx_st = DSP_IDLE;
                     if (st_ff.ch[0].m0_rx)
                     begin
                        nxt_st.ch[0].ri = 1'b1;
                        nxt_st.ch[0].rbuf = {st_ff.rxd_s2, st_ff.ch[0].tx_sh[7:1]};
                     end
                     else
                     begin
                        nxt_st.ch[0].ti = 1'b1;
                     end
                  end
               end
            end
            else if (st_ff.ch[0].ren && !st_ff.ch[0].ri)
            begin
               // A receive transfer starts when enabled and the last byte was taken
               nxt_st.ch[0].tx_st = DSP_RUN;
               nxt_st.ch[0].m0_rx = 1'b1;
               nxt_st.ch[0].tx_bit = 4'h0;
               nxt_st.ch[0].tx_tick = 4'h0;
            end
         end
         else
         begin
            // Transmitter: 16 ticks per bit, flag at the start of the stop bit
            if (st_ff.ch[c].tx_st == DSP_RUN && tk_t[c])
            begin
               nxt_st.ch[c].tx_tick = st_ff.ch[c].tx_tick + 4'h1;
               if (st_ff.ch[c].tx_tick == DSP_TICK_LAST)
               begin
                  nxt_st.ch[c].tx_bit = st_ff.ch[c].tx_bit + 4'h1;
                  if (st_ff.ch[c].tx_bit + 4'h1 == stop_idx(nine))
                  begin
                     nxt_st.ch[c].ti = 1'b1;
                  end
                  if (st_ff.ch[c].tx_bit == stop_idx(nine))
                  begin
                     nxt_st.ch[c].tx_st = DSP_IDLE;
                  end
               end
            end

            // Receiver: falling edge starts, majority of three near centre
            if (st_ff.ch[c].rx_st == DSP_IDLE)
            begin
               if (st_ff.ch[c].ren && st_ff.ch[c].rx_prev && !ln[c])
               begin
                  nxt_st.ch[c].rx_st = DSP_RUN;
                  nxt_st.ch[c].rx_tick = 4'h0;
                  nxt_st.ch[c].rx_bit = 4'h0;
               end
            end
            else if (tk_r[c])
            begin
               nxt_st.ch[c].rx_tick = st_ff.ch[c].rx_tick + 4'h1;
               // Next bit after sixteen ticks
               if (st_ff.ch[c].rx_tick == DSP_TICK_LAST)
               begin
                  nxt_st.ch[c].rx_bit = st_ff.ch[c].rx_bit + 4'h1;
               end
               if (st_ff.ch[c].rx_tick == DSP_TICK_SMP_A ||
                   st_ff.ch[c].rx_tick == DSP_TICK_SMP_B)
               begin
                  nxt_st.ch[c].rx_smp = {st_ff.ch[c].rx_smp[0], ln[c]};
               end
               if (st_ff.ch[c].rx_tick == DSP_TICK_SMP_C)
               begin
                  m = maj3(st_ff.ch[c].rx_smp[1], st_ff.ch[c].rx_smp[0], ln[c]);
                  if (st_ff.ch[c].rx_bit == 4'h0)
                  begin
                     // A start bit that reads high was a glitch
                     if (m)
                     begin
                        nxt_st.ch[c].rx_st = DSP_IDLE;
                     end
                  end
                  else if (st_ff.ch[c].rx_bit < stop_idx(nine))
                  begin
                     nxt_st.ch[c].rx_sh[st_ff.ch[c].rx_bit - 4'h1] = m;
                  end
                  else
                  begin
                     nxt_st.ch[c].rx_st = DSP_IDLE;
                     if (nine)
                     begin
                        if (!(st_ff.ch[c].sm2 && !st_ff.ch[c].rx_sh[8]))
                        begin
                           nxt_st.ch[c].ri = 1'b1;
                           nxt_st.ch[c].rb8 = st_ff.ch[c].rx_sh[8];
                           nxt_st.ch[c].rbuf = st_ff.ch[c].rx_sh[7:0];
                        end
                     end
                     else if (!st_ff.ch[c].sm2 || m)
                     begin
                        nxt_st.ch[c].ri = 1'b1;
                        nxt_st.ch[c].rb8 = m;
                        nxt_st.ch[c].rbuf = st_ff.ch[c].rx_sh[7:0];
                     end
                  end
               end
            end
         end

         // Data write fills the transmit path only; receive byte is untouched
         if (wr_i && addr_i == data_a)
         begin
            nxt_st.ch[c].tx_st = DSP_RUN;
            nxt_st.ch[c].m0_rx = 1'b0;
            nxt_st.ch[c].tx_tick = 4'h0;
            nxt_st.ch[c].tx_bit = 4'h0;
            nxt_st.ch[c].tx_sh = {st_ff.ch[c].tb8, wdata_i};
         end
      end

      // Pin drivers, one register stage behind the engine state
      if (st_ff.ch[0].mode == DSP_MODE_SHIFT)
      begin
         // Clock on the transmit pin, data on the receive pin
         nxt_st.p1_txd = (st_ff.ch[0].tx_st == DSP_IDLE) | st_ff.ch[0].tx_tick[0];
         nxt_st.p1_txd_oe = 1'b1;
         nxt_st.p1_rxd = st_ff.ch[0].tx_sh[0];
         nxt_st.p1_rxd_oe = (st_ff.ch[0].tx_st == DSP_RUN) & ~st_ff.ch[0].m0_rx;
      end
      else
      begin
         nxt_st.p1_txd = tx_level(st_ff.ch[0]);
         // One-wire: release the shared pin whenever no frame is going out
         nxt_st.p1_txd_oe = ~st_ff.one_wire | (st_ff.ch[0].tx_st == DSP_RUN);
         nxt_st.p1_rxd = 1'b1;
         nxt_st.p1_rxd_oe = 1'b0;
      end
      nxt_st.p2_txd = tx_level(st_ff.ch[1]);

      // Read data stands for the one cycle after the strobe
      nxt_st.rdata = 8'h00;
      if (rd_i)
      begin
         case (addr_i)
            DSP_ADDR_PWR_BAUD: nxt_st.rdata = {st_ff.baud_doubler, 7'h00};
            DSP_ADDR_OPTIONS: nxt_st.rdata = {st_ff.one_wire, 7'h00};
            DSP_ADDR_T1_RELOAD: nxt_st.rdata = st_ff.th1;
            DSP_ADDR_RATE_SEL: nxt_st.rdata = {2'h0, st_ff.rclk_t2, st_ff.port1_tx_rate_source_t2, 4'h0};
            DSP_ADDR_P1_CTRL: nxt_st.rdata = {st_ff.ch[0].mode, st_ff.ch[0].sm2,
               st_ff.ch[0].ren, st_ff.ch[0].tb8, st_ff.ch[0].rb8, st_ff.ch[0].ti,
               st_ff.ch[0].ri};
            DSP_ADDR_P1_DATA: nxt_st.rdata = st_ff.ch[0].rbuf;
            DSP_ADDR_P2_CTRL: nxt_st.rdata = {st_ff.ch[1].mode[1], 2'h0,
               st_ff.ch[1].ren, st_ff.ch[1].tb8, st_ff.ch[1].rb8, st_ff.ch[1].ti,
               st_ff.ch[1].ri};
            DSP_ADDR_P2_DATA: nxt_st.rdata = st_ff.ch[1].rbuf;
            default: nxt_st.rdata = 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_ff <= '0;
         st_ff.ch[1].mode <= 2'h1;
         st_ff.p1_txd <= 1'b1;
         st_ff.p1_txd_oe <= 1'b1;
         st_ff.p1_rxd <= 1'b1;
         st_ff.p2_txd <= 1'b1;
      end
      else if (ce_i)
      begin
         st_ff <= nxt_st;
      end
   end

   assign rdata_o = st_ff.rdata;
   assign p1_txd_o = st_ff.p1_txd;
   assign p1_txd_oe_o = st_ff.p1_txd_oe;
   assign p1_rxd_o = st_ff.p1_rxd;
   assign p1_rxd_oe_o = st_ff.p1_rxd_oe;
   assign p2_txd_o = st_ff.p2_txd;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_data_read_split: assert property (
      ce_i && rd_i && addr_i == DSP_ADDR_P1_DATA |=> rdata_o == $past(st_ff.ch[0].rbuf))
      else $error("port one data read does not return the receive byte");

   a_write_starts_tx: assert property (
      ce_i && wr_i && addr_i == DSP_ADDR_P2_DATA |=> st_ff.ch[1].tx_st == DSP_RUN &&
      st_ff.ch[1].tx_sh[7:0] == $past(wdata_i))
      else $error("data write did not start a frame");

   a_rx_blocked_off: assert property (
      st_ff.ch[1].rx_st == DSP_IDLE && !st_ff.ch[1].ren |=> st_ff.ch[1].rx_st == DSP_IDLE)
      else $error("second port started receiving while disabled");

   a_mp_ninth_set: assert property (
      $rose(st_ff.ch[0].ri) && st_ff.ch[0].mode[1] && st_ff.ch[0].sm2 |-> st_ff.ch[0].rb8)
      else $error("filtered nine-bit frame raised the receive flag");

   a_one_wire_release: assert property (
      ce_i && st_ff.one_wire && st_ff.ch[0].mode != DSP_MODE_SHIFT &&
      st_ff.ch[0].tx_st == DSP_IDLE |=> !p1_txd_oe_o)
      else $error("shared pin driven while idle in one-wire mode");

   a_p2_modes_only: assert property (
      st_ff.ch[1].mode[0])
      else $error("second port left its variable-rate modes");

   a_start_bit_low: assert property (
      ce_i && st_ff.ch[0].mode != DSP_MODE_SHIFT && st_ff.ch[0].tx_st == DSP_RUN &&
      st_ff.ch[0].tx_bit == 4'h0 |=> !p1_txd_o)
      else $error("start bit not driven low");

   a_ti2_at_stop: assert property (
      $rose(st_ff.ch[1].ti) && !$past(wr_i) |->
      st_ff.ch[1].tx_bit == stop_idx(st_ff.ch[1].mode[1]))
      else $error("second port transmit flag away from the stop bit");

   a_ti_sticky: assert property (
      st_ff.ch[0].ti && !(ce_i && wr_i && addr_i == DSP_ADDR_P1_CTRL) |=> st_ff.ch[0].ti)
      else $error("transmit flag cleared without a software write");

   a_shift_clock_rate: assert property (
      ce_i && st_ff.ch[0].mode == DSP_MODE_SHIFT && st_ff.ch[0].tx_st == DSP_RUN &&
      !st_ff.ch[0].tx_tick[0] ##1 ce_i |=> p1_txd_o)
      else $error("shift clock not high in the second half of a bit");

   c_p1_rx_done: cover property ($rose(st_ff.ch[0].ri) && st_ff.ch[0].mode != DSP_MODE_SHIFT);
   c_p2_rx_done: cover property ($rose(st_ff.ch[1].ri));
   c_shift_tx_done: cover property ($rose(st_ff.ch[0].ti) && st_ff.ch[0].mode == DSP_MODE_SHIFT);
   c_one_wire_tx: cover property (st_ff.one_wire && st_ff.ch[0].tx_st == DSP_RUN);

endmodule

`default_nettype wire

//--- bench/dsp_remote.sv
// Purpose: Remote serial device at the far end of a port.
// Assumes: Bit time is a fixed count of clocks.
// Notes:   Line idles high between frames.
`default_nettype none
module dsp_remote
#(
   parameter int BITC = 32
)
(
   input wire logic clk_i,
   input wire logic line_i,
   output var logic line_o
);
   initial line_o = 1'b1;
   // Start first, then LSB first; caller builds the frame
   task automatic send(input logic [10:0] f, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk_i);
         line_o <= f[i];
         repeat (BITC - 1) @(posedge clk_i);
      end
      @(posedge clk_i);
      line_o <= 1'b1;
   endtask
   // Samples bit centres; the wait for the start edge is bounded
   task automatic recv(output logic [10:0] f, input int n);
      f = '0;
      for (int w = 0; w < 9999 && line_i; w++)
         @(posedge clk_i);
      repeat (BITC / 2) @(posedge clk_i);
      for (int i = 0; i < n; i++)
      begin
         f[i] = line_i;
         repeat (BITC) @(posedge clk_i);
      end
   endtask
endmodule
`default_nettype wire

//--- bench/dsp_serial_pair_tb.sv
// Purpose: Self-checking bench for the dual serial port pair.
// Assumes: Reload FFh and doubler on give 32 clocks a bit.
// Notes:   Timer2 pulses every second clock; clock enable held high.
`default_nettype none
module dsp_serial_pair_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dsp_pkg::*;
   typedef struct packed {logic [7:0] ca; logic [7:0] ctl; logic [8:0] d;} dsp_row_t;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic sel2 = 1'b0;
   logic [7:0] rdata;
   logic txd1, txd1_oe, txd2, far_o;
   logic p1_rxd, p1_rxd_oe;
   logic t2_ovf = 1'b0;
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc = 0;
   int nb;
   logic [10:0] got;
   dsp_row_t r;
   dsp_row_t rows [5] = '{'{8'h8E, 8'h10, 9'h0A5}, '{8'h8E, 8'h98, 9'h13C},
      '{8'h98, 8'h50, 9'h05A}, '{8'h98, 8'hD0, 9'h0C3}, '{8'h98, 8'h98, 9'h181}};
   // Released pin reads high through its pull-up
   wire logic pin1 = txd1_oe ? txd1 : 1'b1;
   wire logic far_i = sel2 ? txd2 : pin1;
   wire logic rx1 = sel2 ? 1'b1 : far_o;
   wire logic rx2 = sel2 ? far_o : 1'b1;

   dsp_serial_pair uut
   (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .timer2_ovf_i(t2_ovf), .p1_txd_i(pin1),
      .p1_txd_o(txd1), .p1_txd_oe_o(txd1_oe), .p1_rxd_i(rx1), .p1_rxd_o(p1_rxd),
      .p1_rxd_oe_o(p1_rxd_oe), .p2_rxd_i(rx2), .p2_txd_o(txd2)
   );
   dsp_remote m (.clk_i(clk_i), .line_i(far_i), .line_o(far_o));

   initial forever #5 clk_i = ~clk_i;

   function automatic logic [10:0] frm(input logic [8:0] d, input logic nine);
      return nine ? {2'b11, d, 1'b0} : {2'b01, d[7:0], 1'b0};
   endfunction
   task automatic chk(input logic [10:0] g, e);
      num_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %0t got %0h exp %0h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk_i);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, e);
      @(posedge clk_i);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_i);
      rd_s <= 1'b0;
      #1;
      chk({3'h0, rdata}, {3'h0, e});
   endtask
   // Far end of shift mode: takes the data pin on each rising shift clock
   task automatic shift_out(input logic [7:0] d);
      logic [7:0] s;
      s = 8'h00;
      wr(DSP_ADDR_P1_DATA, d);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge txd1);
         // Data only counts while the pin is driven
         s[i] = p1_rxd_oe ? p1_rxd : 1'bx;
      end
      chk({3'h0, s}, {3'h0, d});
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      t2_ovf <= ~t2_ovf;
      if (cyc == 30000)
      begin
         n_mismatch++;
         end_of_test;
      end
   end

   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(DSP_ADDR_P1_CTRL, 8'h00);
      rd(DSP_ADDR_P2_CTRL, 8'h00);
      rd(8'h50, 8'h00);
      $display("reset test done");
      wr(DSP_ADDR_T1_RELOAD, 8'hFF);
      wr(DSP_ADDR_PWR_BAUD, 8'h80);
      // Timer1 climbs from zero once before the reload byte sets the rate
      repeat (520) @(posedge clk_i);
      foreach (rows[i])
      begin
         r = rows[i];
         nb = r.ctl[7] ? 11 : 10;
         sel2 = (r.ca == DSP_ADDR_P2_CTRL);
         wr(r.ca, r.ctl);
         wr(r.ca + 8'h01, r.d[7:0]);
         m.recv(got, nb);
         chk(got, frm(r.d, r.ctl[7]));
         rd(r.ca, r.ctl | 8'h02);
         wr(r.ca, r.ctl);
         m.send(frm({r.d[8], ~r.d[7:0]}, r.ctl[7]), nb);
         rd(r.ca, r.ctl | {5'h00, ~r.ctl[7] | r.d[8], 2'h1});
         rd(r.ca + 8'h01, ~r.d[7:0]);
         $display("row %0d done", i);
      end
      sel2 = 1'b1;
      wr(DSP_ADDR_P2_CTRL, 8'h00);
      m.send(frm(9'h055, 1'b0), 10);
      rd(DSP_ADDR_P2_CTRL, 8'h00);
      sel2 = 1'b0;
      wr(DSP_ADDR_P1_CTRL, 8'hF0);
      m.send(frm(9'h066, 1'b1), 11);
      rd(DSP_ADDR_P1_CTRL, 8'hF0);
      m.send(frm(9'h177, 1'b1), 11);
      rd(DSP_ADDR_P1_CTRL, 8'hF5);
      rd(DSP_ADDR_P1_DATA, 8'h77);
      wr(DSP_ADDR_P1_CTRL, 8'h70);
      // Frame whose stop bit is low
      m.send(11'h0CC, 10);
      rd(DSP_ADDR_P1_CTRL, 8'h70);
      $display("filter test done");
      wr(DSP_ADDR_P1_CTRL, 8'h00);
      shift_out(8'hA5);
      rd(DSP_ADDR_P1_CTRL, 8'h02);
      // Shift receive starts once allowed; the idle far end gives all ones
      wr(DSP_ADDR_P1_CTRL, 8'h10);
      repeat (20) @(posedge clk_i);
      rd(DSP_ADDR_P1_CTRL, 8'h11);
      rd(DSP_ADDR_P1_DATA, 8'hFF);
      $display("shift test done");
      // Undoubled Timer1 would give 64 clocks a bit, so only Timer2 fits the far end
      wr(DSP_ADDR_PWR_BAUD, 8'h00);
      wr(DSP_ADDR_RATE_SEL, 8'h30);
      wr(DSP_ADDR_P1_CTRL, 8'h50);
      wr(DSP_ADDR_P1_DATA, 8'h96);
      m.recv(got, 10);
      chk(got, frm(9'h096, 1'b0));
      m.send(frm(9'h069, 1'b0), 10);
      rd(DSP_ADDR_P1_DATA, 8'h69);
      $display("timer2 test done");
      wr(DSP_ADDR_OPTIONS, 8'h80);
      wr(DSP_ADDR_P1_CTRL, 8'h50);
      wr(DSP_ADDR_P1_DATA, 8'h3C);
      m.recv(got, 10);
      chk(got, frm(9'h03C, 1'b0));
      rd(DSP_ADDR_P1_CTRL, 8'h57);
      rd(DSP_ADDR_P1_DATA, 8'h3C);
      $display("single pin test done");
      end_of_test;
   end
endmodule
`default_nettype wire
